/* verilog/cpu_regs_pkg.sv */
// Functional notes
// RULE_01: four 16-bit general data registers
// RULE_02: first two data registers split into bytes
// RULE_03: third/first and fourth/second form 32-bit pairs
// RULE_04: two 16-bit address registers as operands
// RULE_05: address registers pair, second is upper
// RULE_06: 16-bit frame base register
// RULE_07: 20-bit vector table base register
// RULE_08: 20-bit program counter, next instruction address
// RULE_09: user/interrupt stack pointers chosen by flag
// RULE_10: 16-bit static base register
// RULE_11: 11-bit flag register of processor state
// RULE_12: carry flag captures unit carry/borrow/shift-out
// RULE_13: software keeps debug flag cleared
// RULE_14: zero flag set when result is zero
// RULE_15: sign flag set when result negative
// RULE_16: bank flag selects banked register copy
// RULE_17: overflow flag set on signed overflow
// RULE_18: byte writes keep other half; pairs atomic
package cpu_regs_pkg;
  localparam int DATA_W = 16;
  localparam int WIDE_W = 20;
  localparam int FLAG_W = 11;
  localparam int IDX_W  = 4;
  localparam int ADDR_W = 12;
  // register byte addresses on the bus
  localparam logic [ADDR_W-1:0] OFF_DATA0  = 12'h000;
  localparam logic [ADDR_W-1:0] OFF_DATA1  = 12'h004;
  localparam logic [ADDR_W-1:0] OFF_DATA2  = 12'h008;
  localparam logic [ADDR_W-1:0] OFF_DATA3  = 12'h00C;
  localparam logic [ADDR_W-1:0] OFF_ADDR0  = 12'h010;
  localparam logic [ADDR_W-1:0] OFF_ADDR1  = 12'h014;
  localparam logic [ADDR_W-1:0] OFF_FB     = 12'h018;
  localparam logic [ADDR_W-1:0] OFF_SB     = 12'h01C;
  localparam logic [ADDR_W-1:0] OFF_USP    = 12'h020;
  localparam logic [ADDR_W-1:0] OFF_ISP    = 12'h024;
  localparam logic [ADDR_W-1:0] OFF_VTB    = 12'h028;
  localparam logic [ADDR_W-1:0] OFF_PC     = 12'h02C;
  localparam logic [ADDR_W-1:0] OFF_FLAGS  = 12'h030;
  localparam logic [ADDR_W-1:0] OFF_DPLOW  = 12'h034;
  localparam logic [ADDR_W-1:0] OFF_DPHIGH = 12'h038;
  localparam logic [ADDR_W-1:0] OFF_APAIR  = 12'h03C;
  // flag bit positions
  localparam int FLG_C = 0;
  localparam int FLG_D = 1;
  localparam int FLG_Z = 2;
  localparam int FLG_S = 3;
  localparam int FLG_B = 4;
  localparam int FLG_O = 5;
  localparam int FLG_U = 7;
  // reset values
  localparam logic [DATA_W-1:0] RST_DATA  = 16'h0000;
  localparam logic [WIDE_W-1:0] RST_WIDE  = 20'h00000;
  localparam logic [FLAG_W-1:0] RST_FLAGS = 11'h000;
  // core-side register index
  localparam logic [IDX_W-1:0] IX_DATA0 = 4'h0;
  localparam logic [IDX_W-1:0] IX_DATA1 = 4'h1;
  localparam logic [IDX_W-1:0] IX_DATA2 = 4'h2;
  localparam logic [IDX_W-1:0] IX_DATA3 = 4'h3;
  localparam logic [IDX_W-1:0] IX_ADDR0 = 4'h4;
  localparam logic [IDX_W-1:0] IX_ADDR1 = 4'h5;
  localparam logic [IDX_W-1:0] IX_FB    = 4'h6;
  localparam logic [IDX_W-1:0] IX_SB    = 4'h7;
  localparam logic [IDX_W-1:0] IX_SP    = 4'h8;
  // core write sizes
  typedef enum logic [2:0] {
    SZ_WORD  = 3'b000,
    SZ_LOW   = 3'b001,
    SZ_HIGH  = 3'b010,
    SZ_PAIR  = 3'b011,
    SZ_NONE  = 3'b100
  } wsize_t;
endpackage : cpu_regs_pkg

/* verilog/banked_reg.sv */
`timescale 1ns/1ns
module banked_reg #(
  parameter int W = 16
) (
  input  wire logic         sys_clk,  // clock
  input  wire logic         srst,     // sync reset
  input  wire logic         ce,       // clock enable
  input  wire logic         bank,     // selected bank
  input  wire logic         wrLow,    // write low byte
  input  wire logic         wrHigh,   // write upper bits
  input  wire logic [W-1:0] wData,    // write data
  output logic      [W-1:0] rData     // selected copy
);
  logic [W-1:0] copy0_q;
  logic [W-1:0] copy1_q;
  wire  [W-1:0] cur     = bank ? copy1_q : copy0_q;
  wire  [W-1:0] nextVal = {wrHigh ? wData[W-1:8] : cur[W-1:8],
                           wrLow ? wData[7:0] : cur[7:0]}; // see RULE_18
  assign rData = cur;
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      copy0_q <= '0;
      copy1_q <= '0;
    end else if (ce && (wrLow || wrHigh)) begin
      if (bank) copy1_q <= nextVal; // see RULE_16
      else copy0_q <= nextVal;
    end
  end
endmodule : banked_reg

/* verilog/cpu_register_file_flags.sv */
// The implementer's own choices: the APB register port and the address map.
`timescale 1ns/1ns
module cpu_register_file_flags (
  input  wire logic                           sys_clk,     // 125 MHz clock
  input  wire logic                           srst,        // sync reset
  input  wire logic                           ce,          // clock enable
  input  wire logic                           psel,        // apb select
  input  wire logic                           penable,     // apb enable
  input  wire logic                           pwrite,      // apb direction
  input  wire logic [cpu_regs_pkg::ADDR_W-1:0] paddr,      // apb address
  input  wire logic [31:0]                    pwdata,      // apb write data
  input  wire logic [3:0]                     pstrb,       // apb byte strobes
  output logic                                pready,      // apb ready
  output logic      [31:0]                    prdata,      // apb read data
  output logic                                pslverr,     // apb error
  input  wire logic [cpu_regs_pkg::IDX_W-1:0] rdIdxA,      // operand a index
  input  wire logic [cpu_regs_pkg::IDX_W-1:0] rdIdxB,      // operand b index
  output logic      [31:0]                    rdDataA,     // operand a value
  output logic      [31:0]                    rdDataB,     // operand b value
  input  wire logic                           wrEn,        // core write
  input  wire logic [cpu_regs_pkg::IDX_W-1:0] wrIdx,       // core write index
  input  wire cpu_regs_pkg::wsize_t           wrSize,      // core write size
  input  wire logic [31:0]                    wrData,      // core write data
  input  wire logic                           pcLoad,      // load program counter
  input  wire logic [cpu_regs_pkg::WIDE_W-1:0] pcNext,     // next instruction addr
  input  wire logic                           flagUpd,     // alu result valid
  input  wire logic                           aluCarry,    // carry/borrow/shift-out
  input  wire logic                           aluOvf,      // signed overflow
  input  wire logic [31:0]                    aluResult,   // alu result
  input  wire logic                           aluWide,     // result is 32-bit
  input  wire logic                           aluByte,     // result is 8-bit
  output logic      [cpu_regs_pkg::WIDE_W-1:0] programCounter,  // current pc
  output logic      [cpu_regs_pkg::WIDE_W-1:0] vectorTableBase, // vector base
  output logic      [cpu_regs_pkg::DATA_W-1:0] frameBase,       // frame base
  output logic      [cpu_regs_pkg::DATA_W-1:0] staticBase,      // static base
  output logic      [cpu_regs_pkg::DATA_W-1:0] activeStackPointer, // selected sp
  output logic      [31:0]                    addrPair,    // address pair
  output logic      [cpu_regs_pkg::FLAG_W-1:0] cpuFlags    // flag register
);
  import cpu_regs_pkg::*;

  logic [DATA_W-1:0] data0, data1, data2, data3;
  logic [DATA_W-1:0] addr0_q, addr1_q, fb_q, sb_q, usp_q, isp_q;
  logic [WIDE_W-1:0] pc_q, vtb_q;
  logic [FLAG_W-1:0] flags_q;
  logic [31:0]       prdata_q;

  // apb decode, zero wait states
  wire apbWr = psel && penable && pwrite && ce;
  // read data loaded in setup so it stands while pready is sampled
  wire apbRd = psel && !penable && !pwrite && ce;
  wire hit0  = paddr == OFF_DATA0;
  wire hit1  = paddr == OFF_DATA1;
  wire hit2  = paddr == OFF_DATA2;
  wire hit3  = paddr == OFF_DATA3;
  wire hitA0 = paddr == OFF_ADDR0;
  wire hitA1 = paddr == OFF_ADDR1;
  wire hitFb = paddr == OFF_FB;
  wire hitSb = paddr == OFF_SB;
  wire hitUs = paddr == OFF_USP;
  wire hitIs = paddr == OFF_ISP;
  wire hitVt = paddr == OFF_VTB;
  wire hitPc = paddr == OFF_PC;
  wire hitFl = paddr == OFF_FLAGS;
  wire hitDl = paddr == OFF_DPLOW;
  wire hitDh = paddr == OFF_DPHIGH;
  wire hitAp = paddr == OFF_APAIR;
  wire mapped = hit0 | hit1 | hit2 | hit3 | hitA0 | hitA1 | hitFb | hitSb | hitUs
                | hitIs | hitVt | hitPc | hitFl | hitDl | hitDh | hitAp;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prdata  = prdata_q;

  // core write decode
  wire cw     = wrEn && ce;
  wire cwWord = cw && (wrSize == SZ_WORD);
  wire cwLow  = cw && (wrSize == SZ_LOW);
  wire cwHigh = cw && (wrSize == SZ_HIGH);
  wire cwPair = cw && (wrSize == SZ_PAIR);
  wire cwIs0  = wrIdx == IX_DATA0;
  wire cwIs1  = wrIdx == IX_DATA1;
  // byte access only on the first two data registers
  wire cwByteOk = cwIs0 || cwIs1; // see RULE_02

  // per-register byte-lane enables from core and bus
  wire [3:0] wL, wH;
  wire [DATA_W-1:0] wD [4];
  wire bank = flags_q[FLG_B];

  // data0: core word/byte, low half of data_pair_low
  assign wL[0] = (cwIs0 && (cwWord || (cwLow && cwByteOk) || cwPair))
                 || (apbWr && (hit0 || hitDl) && pstrb[0]); // see RULE_02
  assign wH[0] = (cwIs0 && (cwWord || (cwHigh && cwByteOk) || cwPair))
                 || (apbWr && (hit0 || hitDl) && pstrb[1]);
  // data1: core word/byte, low half of data_pair_high
  assign wL[1] = (cwIs1 && (cwWord || (cwLow && cwByteOk) || cwPair))
                 || (apbWr && (hit1 || hitDh) && pstrb[0]);
  assign wH[1] = (cwIs1 && (cwWord || (cwHigh && cwByteOk) || cwPair))
                 || (apbWr && (hit1 || hitDh) && pstrb[1]);
  // data2/data3 upper halves of pairs; paired write hits both at once
  assign wL[2] = (wrIdx == IX_DATA2 && cwWord) || (cwIs0 && cwPair)
                 || (apbWr && ((hit2 && pstrb[0]) || (hitDl && pstrb[2]))); // see RULE_03
  assign wH[2] = (wrIdx == IX_DATA2 && cwWord) || (cwIs0 && cwPair)
                 || (apbWr && ((hit2 && pstrb[1]) || (hitDl && pstrb[3]))); // see RULE_18
  assign wL[3] = (wrIdx == IX_DATA3 && cwWord) || (cwIs1 && cwPair)
                 || (apbWr && ((hit3 && pstrb[0]) || (hitDh && pstrb[2]))); // see RULE_03
  assign wH[3] = (wrIdx == IX_DATA3 && cwWord) || (cwIs1 && cwPair)
                 || (apbWr && ((hit3 && pstrb[1]) || (hitDh && pstrb[3])));

  // core has priority over the bus for write data
  wire [DATA_W-1:0] cwLo  = cwHigh ? {wrData[7:0], 8'h00} : wrData[15:0];
  wire [DATA_W-1:0] busHi = (hitDl || hitDh) ? pwdata[31:16] : pwdata[15:0];
  assign wD[0] = cw ? cwLo : pwdata[15:0];
  assign wD[1] = cw ? cwLo : pwdata[15:0];
  assign wD[2] = cw ? (cwPair ? wrData[31:16] : wrData[15:0]) : busHi;
  assign wD[3] = cw ? (cwPair ? wrData[31:16] : wrData[15:0]) : busHi;

  logic [DATA_W-1:0] dOut [4];
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : gData
      banked_reg #(.W(DATA_W)) uReg (
        .sys_clk (sys_clk),
        .srst    (srst),
        .ce      (ce),
        .bank    (bank),
        .wrLow   (wL[g]),
        .wrHigh  (wH[g]),
        .wData   (wD[g]),
        .rData   (dOut[g])
      ); // see RULE_01
    end
  endgenerate
  assign data0 = dOut[0];
  assign data1 = dOut[1];
  assign data2 = dOut[2];
  assign data3 = dOut[3];

  // stack pointer select
  wire useUsp = flags_q[FLG_U]; // see RULE_09
  assign activeStackPointer = useUsp ? usp_q : isp_q;

  // other register write enables
  wire cwA0 = cw && ((wrIdx == IX_ADDR0 && cwWord) || (wrIdx == IX_ADDR0 && cwPair));
  wire cwA1 = cw && ((wrIdx == IX_ADDR1 && cwWord) || (wrIdx == IX_ADDR0 && cwPair));
  wire wA0  = cwA0 || (apbWr && (hitA0 || hitAp)); // see RULE_04
  wire wA1  = cwA1 || (apbWr && (hitA1 || hitAp)); // see RULE_05
  wire [DATA_W-1:0] a0D = cwA0 ? wrData[15:0] : pwdata[15:0];
  wire [DATA_W-1:0] a1D = cwA1 ? (cwPair ? wrData[31:16] : wrData[15:0])
                               : (hitAp ? pwdata[31:16] : pwdata[15:0]);
  wire cwFb = cwWord && wrIdx == IX_FB;
  wire cwSb = cwWord && wrIdx == IX_SB;
  wire cwSp = cwWord && wrIdx == IX_SP;
  wire wUsp = (cwSp && useUsp) || (apbWr && hitUs);
  wire wIsp = (cwSp && !useUsp) || (apbWr && hitIs);

  // flag results
  logic zeroRes, signRes;
  always_comb begin
    if (aluWide) begin
      zeroRes = aluResult == 32'h00000000;
      signRes = aluResult[31];
    end else if (aluByte) begin
      zeroRes = aluResult[7:0] == 8'h00;
      signRes = aluResult[7];
    end else begin
      zeroRes = aluResult[15:0] == 16'h0000;
      signRes = aluResult[15];
    end
  end
  logic [FLAG_W-1:0] flags_d;
  always_comb begin
    flags_d = flags_q;
    if (apbWr && hitFl) flags_d = pwdata[FLAG_W-1:0]; // see RULE_11
    if (cw && wrIdx == IX_SP && wrSize == SZ_NONE) flags_d = wrData[FLAG_W-1:0];
    if (flagUpd) begin
      flags_d[FLG_C] = aluCarry; // see RULE_12
      flags_d[FLG_Z] = zeroRes;  // see RULE_14
      flags_d[FLG_S] = signRes;  // see RULE_15
      flags_d[FLG_O] = aluOvf;   // see RULE_17
    end
  end

  // bus read mux
  logic [31:0] rdMux;
  always_comb begin
    rdMux = 32'h00000000;
    if (hit0) rdMux = {16'h0000, data0};
    if (hit1) rdMux = {16'h0000, data1};
    if (hit2) rdMux = {16'h0000, data2};
    if (hit3) rdMux = {16'h0000, data3};
    if (hitA0) rdMux = {16'h0000, addr0_q};
    if (hitA1) rdMux = {16'h0000, addr1_q};
    if (hitFb) rdMux = {16'h0000, fb_q};
    if (hitSb) rdMux = {16'h0000, sb_q};
    if (hitUs) rdMux = {16'h0000, usp_q};
    if (hitIs) rdMux = {16'h0000, isp_q};
    if (hitVt) rdMux = {12'h000, vtb_q};
    if (hitPc) rdMux = {12'h000, pc_q};
    if (hitFl) rdMux = {21'h000000, flags_q};
    if (hitDl) rdMux = {data2, data0};
    if (hitDh) rdMux = {data3, data1};
    if (hitAp) rdMux = {addr1_q, addr0_q};
  end

  // core operand read ports
  function automatic logic [31:0] opSel(input logic [IDX_W-1:0] ix);
    case (ix)
      IX_DATA0: opSel = {data2, data0}; // see RULE_03
      IX_DATA1: opSel = {data3, data1};
      IX_DATA2: opSel = {16'h0000, data2};
      IX_DATA3: opSel = {16'h0000, data3};
      IX_ADDR0: opSel = {addr1_q, addr0_q}; // see RULE_05
      IX_ADDR1: opSel = {16'h0000, addr1_q};
      IX_FB:    opSel = {16'h0000, fb_q};
      IX_SB:    opSel = {16'h0000, sb_q};
      IX_SP:    opSel = {16'h0000, activeStackPointer};
      default:  opSel = 32'h00000000;
    endcase
  endfunction : opSel

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      addr0_q  <= RST_DATA;
      addr1_q  <= RST_DATA;
      fb_q     <= RST_DATA;
      sb_q     <= RST_DATA;
      usp_q    <= RST_DATA;
      isp_q    <= RST_DATA;
      pc_q     <= RST_WIDE;
      vtb_q    <= RST_WIDE;
      flags_q  <= RST_FLAGS;
      prdata_q <= 32'h00000000;
      rdDataA  <= 32'h00000000;
      rdDataB  <= 32'h00000000;
    end else if (ce) begin
      if (wA0) addr0_q <= a0D;
      if (wA1) addr1_q <= a1D;
      if (cwFb || (apbWr && hitFb)) fb_q <= cwFb ? wrData[15:0] : pwdata[15:0]; // see RULE_06
      if (cwSb || (apbWr && hitSb)) sb_q <= cwSb ? wrData[15:0] : pwdata[15:0]; // see RULE_10
      if (wUsp) usp_q <= cwSp ? wrData[15:0] : pwdata[15:0];
      if (wIsp) isp_q <= cwSp ? wrData[15:0] : pwdata[15:0];
      if (apbWr && hitVt) vtb_q <= pwdata[WIDE_W-1:0]; // see RULE_07
      if (pcLoad) pc_q <= pcNext; // see RULE_08
      else if (apbWr && hitPc) pc_q <= pwdata[WIDE_W-1:0];
      flags_q <= flags_d;
      if (apbRd) prdata_q <= rdMux;
      rdDataA <= opSel(rdIdxA);
      rdDataB <= opSel(rdIdxB);
    end
  end

  assign programCounter  = pc_q;
  assign vectorTableBase = vtb_q;
  assign frameBase       = fb_q;
  assign staticBase      = sb_q;
  assign addrPair        = {addr1_q, addr0_q};
  assign cpuFlags        = flags_q;
endmodule : cpu_register_file_flags

/* test/cpu_regs_asserts.sv */
`timescale 1ns/1ns
module cpu_regs_asserts (
  input wire logic                             sys_clk,        // clock
  input wire logic                             srst,           // reset
  input wire logic                             ce,             // enable
  input wire logic [cpu_regs_pkg::IDX_W-1:0]   rdIdxA,         // index
  input wire logic [31:0]                      rdDataA,        // operand
  input wire logic                             wrEn,           // core write
  input wire logic [cpu_regs_pkg::IDX_W-1:0]   wrIdx,          // write index
  input wire cpu_regs_pkg::wsize_t             wrSize,         // write size
  input wire logic [31:0]                      wrData,         // write data
  input wire logic                             pcLoad,         // pc load
  input wire logic [cpu_regs_pkg::WIDE_W-1:0]  pcNext,         // next pc
  input wire logic                             flagUpd,        // alu valid
  input wire logic                             aluCarry,       // carry
  input wire logic                             aluOvf,         // overflow
  input wire logic [31:0]                      aluResult,      // result
  input wire logic                             aluWide,        // 32-bit
  input wire logic                             aluByte,        // 8-bit
  input wire logic [cpu_regs_pkg::WIDE_W-1:0]  programCounter, // pc
  input wire logic [31:0]                      addrPair,       // pair
  input wire logic [cpu_regs_pkg::FLAG_W-1:0]  cpuFlags        // flags
);
  import cpu_regs_pkg::*;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  sequence s_alu;
    ce && flagUpd && !aluWide && !aluByte;
  endsequence
  property p_carry; s_alu |=> cpuFlags[FLG_C] == $past(aluCarry); endproperty
  a_carry: assert property (p_carry) else $error("carry flag wrong");
  property p_zero; s_alu |=> cpuFlags[FLG_Z] == ($past(aluResult[15:0]) == 16'h0000); endproperty
  a_zero: assert property (p_zero) else $error("zero flag wrong");
  property p_sign; s_alu |=> cpuFlags[FLG_S] == $past(aluResult[15]); endproperty
  a_sign: assert property (p_sign) else $error("sign flag wrong");
  property p_ovf; s_alu |=> cpuFlags[FLG_O] == $past(aluOvf); endproperty
  a_ovf: assert property (p_ovf) else $error("overflow flag wrong");
  property p_pc; ce && pcLoad |=> programCounter == $past(pcNext); endproperty
  a_pc: assert property (p_pc) else $error("pc not loaded");
  property p_apair;
    ce && wrEn && wrIdx == IX_ADDR0 && wrSize == SZ_PAIR |=> addrPair == $past(wrData);
  endproperty
  a_apair: assert property (p_apair) else $error("pair write wrong");
  property p_rdpair; ce && rdIdxA == IX_ADDR0 |=> rdDataA == $past(addrPair); endproperty
  a_rdpair: assert property (p_rdpair) else $error("pair read wrong");
  property p_word;
    ce && wrEn && wrIdx == IX_ADDR0 && wrSize == SZ_WORD |=>
      addrPair == {$past(addrPair[31:16]), $past(wrData[15:0])};
  endproperty
  a_word: assert property (p_word) else $error("word write wrong");
endmodule : cpu_regs_asserts
bind cpu_register_file_flags cpu_regs_asserts cpu_regs_asserts_inst (
  .sys_clk(sys_clk), .srst(srst), .ce(ce), .rdIdxA(rdIdxA), .rdDataA(rdDataA),
  .wrEn(wrEn), .wrIdx(wrIdx), .wrSize(wrSize), .wrData(wrData), .pcLoad(pcLoad),
  .pcNext(pcNext), .flagUpd(flagUpd), .aluCarry(aluCarry), .aluOvf(aluOvf),
  .aluResult(aluResult), .aluWide(aluWide), .aluByte(aluByte),
  .programCounter(programCounter), .addrPair(addrPair), .cpuFlags(cpuFlags));

/* test/alu_model.sv */
`timescale 1ns/1ns
module alu_model (
  input  wire logic        sys_clk,   // clock
  input  wire logic        go,        // start add
  input  wire logic [15:0] opA,       // operand
  input  wire logic [15:0] opB,       // operand
  output logic             flagUpd,   // result valid
  output logic             aluCarry,  // carry out
  output logic             aluOvf,    // overflow
  output logic      [31:0] aluResult  // sum
);
  logic [16:0] sum;
  assign sum = {1'b0, opA} + {1'b0, opB};
  always_ff @(posedge sys_clk) begin
    flagUpd   <= go;
    aluCarry  <= sum[16];
    aluOvf    <= (opA[15] == opB[15]) && (sum[15] != opA[15]);
    aluResult <= {16'h0000, sum[15:0]};
  end
endmodule : alu_model

/* test/testbench.sv */
`timescale 1ns/1ns
module testbench;
  import cpu_regs_pkg::*;
  logic              sys_clk = 1'b0;
  logic              srst = 1'b1;
  logic              ce = 1'b1;
  logic              psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pcLoad = 1'b0;
  logic              wrEn = 1'b0, go = 1'b0, pready, pslverr, flagUpd, aluCarry, aluOvf, errSeen;
  logic [ADDR_W-1:0] paddr = 12'h000;
  logic [31:0]       pwdata = 32'h0, wrData = 32'h0, prdata, rdDataA, aluResult, addrPair, rd;
  logic [IDX_W-1:0]  rdIdxA = IX_DATA1, wrIdx = IX_DATA0;
  logic [WIDE_W-1:0] pcNext = 20'h00000, programCounter;
  logic [DATA_W-1:0] activeStackPointer, opA = 16'h0000, opB = 16'h0000, fb, sb;
  logic [FLAG_W-1:0] cpuFlags;
  wsize_t            wrSize = SZ_NONE;
  int                bad_count = 0, tests_run = 0;
  cpu_register_file_flags cpu_register_file_flags_inst (
    .sys_clk(sys_clk), .srst(srst), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .rdIdxA(rdIdxA), .rdIdxB(IX_DATA0), .rdDataA(rdDataA), .rdDataB(),
    .wrEn(wrEn), .wrIdx(wrIdx), .wrSize(wrSize), .wrData(wrData), .pcLoad(pcLoad),
    .pcNext(pcNext), .flagUpd(flagUpd), .aluCarry(aluCarry), .aluOvf(aluOvf),
    .aluResult(aluResult), .aluWide(1'b0), .aluByte(1'b0), .programCounter(programCounter),
    .vectorTableBase(), .frameBase(fb), .staticBase(sb), .activeStackPointer(activeStackPointer),
    .addrPair(addrPair), .cpuFlags(cpuFlags));
  alu_model alu_model_inst (.sys_clk(sys_clk), .go(go), .opA(opA), .opB(opB),
    .flagUpd(flagUpd), .aluCarry(aluCarry), .aluOvf(aluOvf), .aluResult(aluResult));
  initial begin
    forever #4 sys_clk = ~sys_clk;
  end
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : print_verdict
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    int n;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      bad_count++;
      print_verdict();
    end
    errSeen = pslverr;
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask : apb
  task automatic cw(input logic [IDX_W-1:0] i, input wsize_t s, input logic [31:0] d);
    @(posedge sys_clk);
    wrEn <= 1'b1;
    wrIdx <= i;
    wrSize <= s;
    wrData <= d;
    @(posedge sys_clk);
    wrEn <= 1'b0;
    @(posedge sys_clk);
  endtask : cw
  task automatic t_regs();
    logic [31:0] m;
    logic [31:0] d;
    for (int a = 0; a <= 48; a += 4) begin
      m = (a == 40 || a == 44) ? 32'h000FFFFF : (a == 48) ? 32'h000007FF : 32'h0000FFFF;
      d = (a == 48) ? 32'hFFFFFFFD : 32'hFFFFFFFF;
      apb(1'b0, a[ADDR_W-1:0], 32'h0);
      chk("reset value", rd, 32'h0);
      apb(1'b1, a[ADDR_W-1:0], d);
      apb(1'b0, a[ADDR_W-1:0], 32'h0);
      chk("reg width", rd, d & m);
    end
    chk("pc port", {12'h000, programCounter}, 32'h000FFFFF);
    chk("fb port", {16'h0000, fb}, 32'h0000FFFF);
    chk("sb port", {16'h0000, sb}, 32'h0000FFFF);
    apb(1'b1, OFF_FLAGS, 32'h0);
    apb(1'b0, 12'h040, 32'h0);
    chk("unmapped", {rd[30:0], errSeen}, 32'h1);
    $display("done t_regs");
  endtask : t_regs
  task automatic t_split();
    cw(IX_DATA0, SZ_WORD, 32'h0000AAAA);
    cw(IX_DATA0, SZ_LOW, 32'h00000055);
    apb(1'b0, OFF_DATA0, 32'h0);
    chk("low byte", rd, 32'h0000AA55);
    cw(IX_DATA1, SZ_HIGH, 32'h00000034);
    apb(1'b0, OFF_DATA1, 32'h0);
    chk("high byte", rd, 32'h000034FF);
    apb(1'b1, OFF_DPLOW, 32'h87654321);
    apb(1'b0, OFF_DATA2, 32'h0);
    chk("pair upper", rd, 32'h00008765);
    rdIdxA <= IX_DATA0;
    @(posedge sys_clk);
    @(posedge sys_clk);
    chk("pair operand", rdDataA, 32'h87654321);
    rdIdxA <= IX_ADDR0;
    cw(IX_ADDR0, SZ_PAIR, 32'hCAFEBEEF);
    chk("addr pair", addrPair, 32'hCAFEBEEF);
    apb(1'b0, OFF_ADDR1, 32'h0);
    chk("addr upper", rd, 32'h0000CAFE);
    cw(IX_ADDR0, SZ_WORD, 32'h00001234);
    chk("addr word", addrPair, 32'hCAFE1234);
    ce <= 1'b0;
    cw(IX_ADDR0, SZ_WORD, 32'h00005555);
    ce <= 1'b1;
    chk("ce freeze", addrPair, 32'hCAFE1234);
    $display("done t_split");
  endtask : t_split
  task automatic t_bank();
    apb(1'b1, OFF_DATA0, 32'h1111);
    apb(1'b1, OFF_FLAGS, 32'h10);
    apb(1'b1, OFF_DATA0, 32'h2222);
    apb(1'b1, OFF_FLAGS, 32'h0);
    apb(1'b0, OFF_DATA0, 32'h0);
    chk("bank 0", rd, 32'h1111);
    apb(1'b1, OFF_ISP, 32'h0BBB);
    chk("isp", {16'h0000, activeStackPointer}, 32'h0BBB);
    apb(1'b1, OFF_FLAGS, 32'h90);
    chk("usp", {16'h0000, activeStackPointer}, 32'h0000FFFF);
    apb(1'b0, OFF_DATA0, 32'h0);
    chk("bank 1", rd, 32'h2222);
    apb(1'b1, OFF_FLAGS, 32'h0);
    $display("done t_bank");
  endtask : t_bank
  task automatic t_alu(input logic [15:0] a, input logic [15:0] b, input logic [3:0] e);
    @(posedge sys_clk);
    go <= 1'b1;
    opA <= a;
    opB <= b;
    pcLoad <= 1'b1;
    pcNext <= {4'h1, a};
    @(posedge sys_clk);
    go <= 1'b0;
    pcLoad <= 1'b0;
    @(posedge sys_clk);
    @(posedge sys_clk);
    chk("alu flags", {cpuFlags[FLG_O], cpuFlags[FLG_S], cpuFlags[FLG_Z], cpuFlags[FLG_C]}, e);
    chk("pc load", {12'h000, programCounter}, {16'h0001, a});
    $display("done t_alu");
  endtask : t_alu
  initial begin
    repeat (8) @(posedge sys_clk);
    srst <= 1'b0;
    t_regs();
    t_split();
    t_bank();
    t_alu(16'h7FFF, 16'h0001, 4'b1100);
    t_alu(16'hFFFF, 16'h0001, 4'b0011);
    t_alu(16'h8000, 16'h8000, 4'b1011);
    print_verdict();
  end
endmodule : testbench
